//--- design/afe_pkg.sv
package afe_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_AMP3     = 8'h00;
	localparam logic [7:0] OFS_SW_BASE  = 8'h04;
	localparam logic [7:0] OFS_SW_LAST  = 8'h28;
	localparam logic [7:0] OFS_STRIDE   = 8'h04;
	localparam logic [7:0] OFS_PGA_GAIN = 8'h2c;
	localparam logic [7:0] OFS_PGA_IN   = 8'h30;
	localparam logic [7:0] OFS_PGA_CH   = 8'h34;
	localparam logic [7:0] OFS_RES_LO   = 8'h38;
	localparam logic [7:0] OFS_RES_MID  = 8'h3c;
	localparam logic [7:0] OFS_RES_HI   = 8'h40;
	localparam logic [7:0] OFS_RATE     = 8'h44;
	localparam logic [7:0] OFS_CONV     = 8'h48;
	localparam logic [7:0] OFS_CLKSEL   = 8'h4c;
	localparam logic [7:0] OFS_SWAP     = 8'h50;

	// ----------------------------------------------------------------
	// Implemented-bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_AMP3   = 8'hcf;
	localparam logic [7:0] MASK_SW_A   = 8'hfe;
	localparam logic [7:0] MASK_SW_B   = 8'hff;
	localparam logic [7:0] MASK_SW_C   = 8'h3f;
	localparam logic [7:0] MASK_PGA_IN = 8'hfe;
	localparam logic [7:0] MASK_RATE   = 8'h7f;
	localparam logic [7:0] MASK_CONV   = 8'hbf;
	localparam logic [7:0] MASK_CLKSEL = 8'h1f;
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [7:0] RST_CONV    = 8'h04;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned AMP3_EN_BIT   = 7;
	localparam int unsigned DEMOD_BIT     = 6;
	localparam int unsigned AMP2_OUT_BIT  = 5;
	localparam int unsigned SINE_BIT      = 5;
	localparam int unsigned POS_BIT_A     = 4;
	localparam int unsigned NEG_BIT_A     = 3;
	localparam int unsigned POS_BIT_BC    = 5;
	localparam int unsigned NEG_BIT_BC    = 4;
	localparam int unsigned BYPASS_BIT    = 7;
	localparam int unsigned LATCH_BIT     = 5;
	localparam int unsigned EOC_BIT       = 4;
	localparam int unsigned CONV_RST_BIT  = 3;
	localparam int unsigned CONV_OFF_BIT  = 2;
	localparam int unsigned NUM_PINS      = 10;
	localparam int unsigned NUM_SINE_PINS = 5;
	localparam int unsigned GROUP_C_FIRST = 8;

	// ----------------------------------------------------------------
	// Converter and gain constants
	// ----------------------------------------------------------------
	localparam logic [3:0] OSR_LOG_MAX  = 4'hf;
	localparam logic [3:0] OSR_CODE_MAX = 4'h8;
	localparam logic [3:0] RES_SHIFT    = 4'h8;
	localparam logic [1:0] RESP_OKAY    = 2'b00;
	localparam logic [1:0] RESP_SLVERR  = 2'b10;
	localparam logic [12:0] GAIN_UNITY  = 13'h03e8;
	localparam logic [12:0] AMP3_GAIN_MILLI [0:15] = '{
		13'h03e8, 13'h0474, 13'h051e, 13'h05dc, 13'h06c2, 13'h07d0, 13'h091a, 13'h0abe,
		13'h0cd5, 13'h0fa0, 13'h1388, 13'h03e8, 13'h03e8, 13'h03e8, 13'h03e8, 13'h03e8};

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        enable;
		logic        demod_fwr;
		logic [12:0] gain_milli;
	} afe_amp3_t;

	typedef struct packed {
		logic       bypass;
		logic [1:0] ref_shift;
		logic [2:0] in_gain;
		logic [7:0] amp_gain;
	} afe_pga_t;

	typedef struct packed {
		logic [3:0] neg_sel;
		logic [3:0] pos_sel;
	} afe_chan_t;

endpackage

//--- design/afe_sinc_filter.sv
`timescale 1ns/1ns
module afe_sinc_filter
#(
	parameter int unsigned RES_W = 24,
	parameter int unsigned CNT_W = 16
)
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             run,
	input  wire logic [3:0]       osr_code,
	input  wire logic             bit_in,
	output logic                  done,
	output logic [RES_W-1:0]      result
);
	import afe_pkg::*;

	logic [CNT_W-1:0] sample_cnt_r;
	logic [CNT_W-1:0] ones_r;
	logic [3:0]       code_c;
	logic [3:0]       osr_log;
	logic [CNT_W-1:0] osr_last;
	logic [CNT_W-1:0] ones_nxt;
	logic [31:0]      scaled;

	// Reserved rate codes fall back to the shortest window.
	assign code_c   = (osr_code > OSR_CODE_MAX) ? OSR_CODE_MAX : osr_code;
	assign osr_log  = OSR_LOG_MAX - code_c;
	assign osr_last = (CNT_W'(1) << osr_log) - CNT_W'(1);
	assign ones_nxt = ones_r + CNT_W'(bit_in);
	assign scaled   = 32'(ones_nxt) << (5'(RES_SHIFT) + 5'(code_c)); // Widened so 8 + 8 cannot wrap to 0.

	// Counting-window decimator; a stopped filter drops its partial window.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sample_cnt_r <= '0;
			ones_r       <= '0;
			done         <= 1'b0;
			result       <= '0;
		end
		else if (!run)
		begin
			sample_cnt_r <= '0;
			ones_r       <= '0;
			done         <= 1'b0;
		end
		else if (sample_cnt_r == osr_last)
		begin
			sample_cnt_r <= '0;
			ones_r       <= '0;
			done         <= 1'b1;
			result       <= (scaled > 32'h00ff_ffff) ? '1 : scaled[RES_W-1:0];
		end
		else
		begin
			sample_cnt_r <= sample_cnt_r + CNT_W'(1);
			ones_r       <= ones_nxt;
			done         <= 1'b0;
		end
	end

endmodule

//--- design/afe_switch_gain_regs.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module afe_switch_gain_regs
#(
	parameter int unsigned RES_W = 24,
	parameter int unsigned CNT_W = 16
)
(
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                amp2_digital_out,
	input  wire logic                mod_bit,
	output afe_pkg::afe_amp3_t       amp3_cfg,
	output afe_pkg::afe_pga_t        pga_cfg,
	output afe_pkg::afe_chan_t       chan_sel,
	output logic [4:0]               pin_sine_switch,
	output logic [9:0]               pin_conv_pos_switch,
	output logic [9:0]               pin_conv_neg_switch,
	output logic [7:0]               pga_input_cfg,
	output logic [7:0]               conv_rate_cfg,
	output logic [7:0]               conv_ctrl_cfg,
	output logic [7:0]               conv_clk_cfg,
	output logic [7:0]               mod_swap_cfg
);
	import afe_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0]       amp3_r;
	logic [7:0]       sw_r [NUM_PINS];
	logic [7:0]       pga_gain_r;
	logic [7:0]       pga_in_r;
	logic [7:0]       pga_ch_r;
	logic [7:0]       rate_r;
	logic [7:0]       conv_r;
	logic [7:0]       clksel_r;
	logic [7:0]       swap_r;
	logic [RES_W-1:0] result_r;
	logic             amp2_s1_r;
	logic             amp2_s2_r;
	logic             mod_s1_r;
	logic             mod_s2_r;
	logic             wr_fire;
	logic             wr_en;
	logic             rd_fire;
	logic [7:0]       wbyte;
	logic [7:0]       rd_byte;
	logic             filt_run;
	logic             filt_done;
	logic [RES_W-1:0] filt_result;
	logic             res_update;

	// Word-aligned address inside the register map.
	function automatic logic addr_hit(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			OFS_AMP3, OFS_PGA_GAIN, OFS_PGA_IN, OFS_PGA_CH,
			OFS_RES_LO, OFS_RES_MID, OFS_RES_HI, OFS_RATE,
			OFS_CONV, OFS_CLKSEL, OFS_SWAP:
				hit = 1'b1;
			default:
				hit = (a >= OFS_SW_BASE) && (a <= OFS_SW_LAST) && (a[1:0] == 2'b00);
		endcase
		return hit;
	endfunction

	// Implemented bits of the pin switch register for one pin.
	function automatic logic [7:0] sw_mask(input int unsigned pin);
		logic [7:0] m;
		m = MASK_SW_B;
		if (pin < NUM_SINE_PINS)
			m = MASK_SW_A;
		else if (pin >= GROUP_C_FIRST)
			m = MASK_SW_C;
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------

	// The comparator and modulator bits come from analog logic off this clock.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			amp2_s1_r <= 1'b0;
			amp2_s2_r <= 1'b0;
			mod_s1_r  <= 1'b0;
			mod_s2_r  <= 1'b0;
		end
		else
		begin
			amp2_s1_r <= amp2_digital_out;
			amp2_s2_r <= amp2_s1_r;
			mod_s1_r  <= mod_bit;
			mod_s2_r  <= mod_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign wr_en   = wr_fire && s_axi_wstrb[0] && addr_hit(s_axi_awaddr);
	assign wbyte   = s_axi_wdata[7:0];

	// Address and data are taken together once no response is pending.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
		end
	end

	// Write response stands until the master takes it.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_hit(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------

	// Amplifier three control; the comparator bit is not stored here.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			amp3_r <= RST_ZERO;
		else if (wr_en && s_axi_awaddr == OFS_AMP3)
			amp3_r <= wbyte & MASK_AMP3;
	end

	// One switch register per analog pin, masked by its pin group.
	for (genvar i = 0; i < NUM_PINS; i++)
	begin : g_pin
		always_ff @(posedge core_clk or negedge arst_n)
		begin
			if (!arst_n)
				sw_r[i] <= RST_ZERO;
			else if (wr_en && s_axi_awaddr == OFS_SW_BASE + OFS_STRIDE * 8'(i))
				sw_r[i] <= wbyte & sw_mask(i);
		end
		if (i < NUM_SINE_PINS)
		begin : g_grp_a
			assign pin_sine_switch[i]     = sw_r[i][SINE_BIT];
			assign pin_conv_pos_switch[i] = sw_r[i][POS_BIT_A];
			assign pin_conv_neg_switch[i] = sw_r[i][NEG_BIT_A];
		end
		else
		begin : g_grp_bc
			assign pin_conv_pos_switch[i] = sw_r[i][POS_BIT_BC];
			assign pin_conv_neg_switch[i] = sw_r[i][NEG_BIT_BC];
		end
	end

	// Gain, input and channel setup of the programmable amplifier.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pga_gain_r <= RST_ZERO;
			pga_in_r   <= RST_ZERO;
			pga_ch_r   <= RST_ZERO;
		end
		else if (wr_en)
		begin
			if (s_axi_awaddr == OFS_PGA_GAIN)
				pga_gain_r <= wbyte;
			if (s_axi_awaddr == OFS_PGA_IN)
				pga_in_r <= wbyte & MASK_PGA_IN;
			if (s_axi_awaddr == OFS_PGA_CH)
				pga_ch_r <= wbyte;
		end
	end

	// Converter rate, clock and swap settings.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rate_r   <= RST_ZERO;
			clksel_r <= RST_ZERO;
			swap_r   <= RST_ZERO;
		end
		else if (wr_en)
		begin
			if (s_axi_awaddr == OFS_RATE)
				rate_r <= wbyte & MASK_RATE;
			if (s_axi_awaddr == OFS_CLKSEL)
				clksel_r <= wbyte & MASK_CLKSEL;
			if (s_axi_awaddr == OFS_SWAP)
				swap_r <= wbyte;
		end
	end

	// Converter control; a finished conversion sets its flag over a clear.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			conv_r <= RST_CONV;
		else
		begin
			if (wr_en && s_axi_awaddr == OFS_CONV)
				conv_r <= wbyte & MASK_CONV;
			if (res_update)
				conv_r[EOC_BIT] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Conversion path
	// ----------------------------------------------------------------

	// The filter stops while powered off or held in software reset.
	assign filt_run   = !conv_r[CONV_OFF_BIT] && !conv_r[CONV_RST_BIT];
	assign res_update = filt_done && !conv_r[LATCH_BIT];

	afe_sinc_filter #(
		.RES_W (RES_W),
		.CNT_W (CNT_W)
	) u_sinc (
		.clk      (core_clk),
		.arst_n   (arst_n),
		.run      (filt_run),
		.osr_code (rate_r[3:0]),
		.bit_in   (mod_s2_r),
		.done     (filt_done),
		.result   (filt_result)
	);

	// Result holds while the latch bit is set so reads stay coherent.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			result_r <= '0;
		else if (res_update)
			result_r <= filt_result;
	end

	// ----------------------------------------------------------------
	// Decoded analog controls
	// ----------------------------------------------------------------

	// Amplifier three settings; decoded gain lags its register by a cycle.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			amp3_cfg <= '{enable: 1'b0, demod_fwr: 1'b0, gain_milli: GAIN_UNITY};
		else
		begin
			amp3_cfg.enable     <= amp3_r[AMP3_EN_BIT];
			amp3_cfg.demod_fwr  <= amp3_r[DEMOD_BIT];
			amp3_cfg.gain_milli <= AMP3_GAIN_MILLI[amp3_r[3:0]];
		end
	end

	// Programmable amplifier and converter gains.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pga_cfg <= '{bypass: 1'b0, ref_shift: 2'h0, in_gain: 3'h1, amp_gain: 8'h01};
		else
		begin
			pga_cfg.bypass    <= pga_gain_r[BYPASS_BIT];
			pga_cfg.ref_shift <= pga_gain_r[6:5];
			pga_cfg.in_gain   <= 3'h1 << pga_gain_r[4:3];
			pga_cfg.amp_gain  <= 8'h01 << pga_gain_r[2:0];
		end
	end

	// Independent positive and negative selects serve both input layouts.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			chan_sel <= '0;
		else
		begin
			chan_sel.pos_sel <= pga_ch_r[3:0];
			chan_sel.neg_sel <= pga_ch_r[7:4];
		end
	end

	// Raw setup bytes for the converter's analog and clock logic.
	assign pga_input_cfg = pga_in_r;
	assign conv_rate_cfg = rate_r;
	assign conv_ctrl_cfg = conv_r;
	assign conv_clk_cfg  = clksel_r;
	assign mod_swap_cfg  = swap_r;

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign rd_fire = s_axi_arready && s_axi_arvalid;

	// Read data selection; unmapped addresses return zero.
	always_comb
	begin
		rd_byte = 8'h00;
		case (s_axi_araddr)
			OFS_AMP3:
			begin
				rd_byte               = amp3_r;
				rd_byte[AMP2_OUT_BIT] = amp2_s2_r;
			end
			OFS_PGA_GAIN: rd_byte = pga_gain_r;
			OFS_PGA_IN:   rd_byte = pga_in_r;
			OFS_PGA_CH:   rd_byte = pga_ch_r;
			OFS_RES_LO:   rd_byte = result_r[7:0];
			OFS_RES_MID:  rd_byte = result_r[15:8];
			OFS_RES_HI:   rd_byte = result_r[23:16];
			OFS_RATE:     rd_byte = rate_r;
			OFS_CONV:     rd_byte = conv_r;
			OFS_CLKSEL:   rd_byte = clksel_r;
			OFS_SWAP:     rd_byte = swap_r;
			default:
			begin
				for (int i = 0; i < NUM_PINS; i++)
					if (s_axi_araddr == OFS_SW_BASE + OFS_STRIDE * 8'(i))
						rd_byte = sw_r[i];
			end
		endcase
	end

	// One read at a time; the address is taken when no data is pending.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	end

	// Read data stands until the master takes it.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

//--- tb/afe_switch_gain_regs_props.sv
`timescale 1ns/1ns
// Checker that watches the register bank at its ports only.
module afe_regs_props
(
	input wire logic                core_clk,
	input wire logic                arst_n,
	input wire logic [7:0]          s_axi_awaddr,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic [31:0]         s_axi_wdata,
	input wire logic [3:0]          s_axi_wstrb,
	input wire logic                s_axi_wvalid,
	input wire logic [7:0]          s_axi_araddr,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	input wire logic                amp2_digital_out,
	input wire afe_pkg::afe_amp3_t  amp3_cfg,
	input wire afe_pkg::afe_pga_t   pga_cfg,
	input wire logic [4:0]          pin_sine_switch,
	input wire logic [9:0]          pin_conv_pos_switch,
	input wire logic [9:0]          pin_conv_neg_switch
);
	import afe_pkg::*;
	// Handshakes that really reach a register.
	logic wr_go;
	logic rd_amp3;
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0];
	assign rd_amp3 = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_AMP3;
	// Every check runs on the core clock and is quiet in reset.
	default clocking dck @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	amp3_enable_a: assert property (wr_go && s_axi_awaddr == OFS_AMP3 |=> ##1
		amp3_cfg.enable == $past(s_axi_wdata[7], 2)) else $error("amp3 enable wrong");
	demod_mode_a: assert property (wr_go && s_axi_awaddr == OFS_AMP3 |=> ##1
		amp3_cfg.demod_fwr == $past(s_axi_wdata[6], 2)) else $error("demod mode wrong");
	amp3_gain_a: assert property (wr_go && s_axi_awaddr == OFS_AMP3 |=> ##1
		amp3_cfg.gain_milli == AMP3_GAIN_MILLI[$past(s_axi_wdata[3:0], 2)]) else $error("amp3 gain wrong");
	amp2_read_a: assert property (rd_amp3 && $stable(amp2_digital_out) &&
		amp2_digital_out == $past(amp2_digital_out, 2) && amp2_digital_out == $past(amp2_digital_out, 3)
		|=> s_axi_rdata[5] == $past(amp2_digital_out)) else $error("amp2 bit wrong");
	read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	bypass_sel_a: assert property (wr_go && s_axi_awaddr == OFS_PGA_GAIN |=> ##1
		pga_cfg.bypass == $past(s_axi_wdata[7], 2)) else $error("bypass wrong");
	// Per-pin switch outputs follow their register bits.
	for (genvar i = 0; i < 10; i++)
	begin : g_pin
		localparam logic [7:0] PA = 8'(4 + 4 * i);
		pos_switch_a: assert property (wr_go && s_axi_awaddr == PA |=>
			pin_conv_pos_switch[i] == $past(s_axi_wdata[i < 5 ? 4 : 5])) else $error("pos switch wrong");
		neg_switch_a: assert property (wr_go && s_axi_awaddr == PA |=>
			pin_conv_neg_switch[i] == $past(s_axi_wdata[i < 5 ? 3 : 4])) else $error("neg switch wrong");
		if (i < 5)
		begin : g_sine
			sine_switch_a: assert property (wr_go && s_axi_awaddr == PA |=>
				pin_sine_switch[i] == $past(s_axi_wdata[5])) else $error("sine switch wrong");
		end
	end
endmodule

bind afe_switch_gain_regs afe_regs_props chk_u (.core_clk(core_clk), .arst_n(arst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .amp2_digital_out(amp2_digital_out),
	.amp3_cfg(amp3_cfg), .pga_cfg(pga_cfg), .pin_sine_switch(pin_sine_switch),
	.pin_conv_pos_switch(pin_conv_pos_switch), .pin_conv_neg_switch(pin_conv_neg_switch));

//--- tb/test_afe_switch_gain_regs.sv
`timescale 1ns/1ns
// Bench that drives the register bus and the two analog inputs.
module test_afe_switch_gain_regs;
	import afe_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [31:0] wd = 32'h00000000;
	logic [3:0] ws = 4'h0;
	logic [7:0] ara = 8'h00;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bri = 1'b0;
	logic arv = 1'b0;
	logic rri = 1'b0;
	logic a2 = 1'b0;
	logic mb = 1'b0;
	logic awr, bv, arr, rv;
	logic [1:0] brs, rrs;
	logic [31:0] rdat;
	logic [4:0] sine;
	logic [9:0] pos, neg;
	logic [7:0] pin_c, rate_c, ctl_c, clk_c, swp_c;
	logic wrdy;
	afe_amp3_t amp3;
	afe_pga_t pga;
	afe_chan_t chan;
	logic [12:0] g [0:15] = '{13'h3e8, 13'h474, 13'h51e, 13'h5dc, 13'h6c2, 13'h7d0, 13'h91a, 13'habe,
		13'hcd5, 13'hfa0, 13'h1388, 13'h3e8, 13'h3e8, 13'h3e8, 13'h3e8, 13'h3e8};
	int err_count = 0;
	int check_count = 0;

	afe_switch_gain_regs #(.RES_W(24), .CNT_W(16)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bri),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs),
		.s_axi_rvalid(rv), .s_axi_rready(rri), .amp2_digital_out(a2), .mod_bit(mb), .amp3_cfg(amp3),
		.pga_cfg(pga), .chan_sel(chan), .pin_sine_switch(sine), .pin_conv_pos_switch(pos),
		.pin_conv_neg_switch(neg), .pga_input_cfg(pin_c), .conv_rate_cfg(rate_c), .conv_ctrl_cfg(ctl_c),
		.conv_clk_cfg(clk_c), .mod_swap_cfg(swp_c));

	// Free-running core clock.
	initial
	begin
		forever #50 core_clk = ~core_clk;
	end

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic fail_out();
		err_count++;
		close_out();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	// Waits, bounded, for awready, bvalid, arready or rvalid.
	task automatic wait_for(input int w);
		int n;
		n = 0;
		while ((w == 0 ? awr : w == 1 ? bv : w == 2 ? arr : rv) !== 1'b1)
		begin
			tick();
			n++;
			if (n > 50)
				fail_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge core_clk);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bri <= 1'b1;
		#1;
		wait_for(0);
		chk(32'(wrdy), 32'h1);
		@(posedge core_clk);
		awv <= 1'b0;
		wv <= 1'b0;
		#1;
		wait_for(1);
		chk(32'(brs), 32'(er));
		@(posedge core_clk);
		bri <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		ara <= a;
		arv <= 1'b1;
		rri <= 1'b1;
		#1;
		wait_for(2);
		@(posedge core_clk);
		arv <= 1'b0;
		#1;
		wait_for(3);
		d = rdat;
		r = rrs;
		@(posedge core_clk);
		rri <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask

	// Main sequence of register scenarios.
	initial
	begin
		int i, k, b;
		logic [7:0] pa;
		logic [31:0] d;
		logic [1:0] r;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		rc(OFS_AMP3, 32'h00, RESP_OKAY);
		rc(OFS_PGA_GAIN, 32'h00, RESP_OKAY);
		rc(OFS_CONV, 32'h04, RESP_OKAY);
		chk(32'(ctl_c), 32'h04);
		chk(32'(amp3.gain_milli), 32'h3e8);
		chk(32'(pga.amp_gain), 32'h1);
		wr(8'h54, 32'hff, 4'h1, RESP_SLVERR);
		rc(8'h54, 32'h00, RESP_SLVERR);
		a2 <= 1'b1;
		wr(OFS_AMP3, 32'hffffffff, 4'hf, RESP_OKAY);
		rc(OFS_AMP3, 32'hef, RESP_OKAY);
		chk(32'(amp3.enable), 32'h1);
		chk(32'(amp3.demod_fwr), 32'h1);
		a2 <= 1'b0;
		wr(OFS_AMP3, 32'h80, 4'he, RESP_OKAY);
		rc(OFS_AMP3, 32'hcf, RESP_OKAY);
		for (i = 0; i < 16; i++)
		begin
			wr(OFS_AMP3, 32'(i), 4'h1, RESP_OKAY);
			tick();
			chk(32'(amp3.gain_milli), 32'(g[i]));
		end
		chk(32'(amp3.enable), 32'h0);
		chk(32'(amp3.demod_fwr), 32'h0);
		// One switch closed at a time on each pin.
		for (i = 0; i < 10; i++)
		begin
			pa = OFS_SW_BASE + 8'(4 * i);
			rc(pa, 32'h00, RESP_OKAY);
			for (k = 0; k < 3; k++)
			begin
				if (k < 2 || i < 5)
				begin
					b = (k == 0) ? 4 : (k == 1) ? 3 : 5;
					if (i > 4)
						b++;
					wr(pa, 32'h1 << b, 4'h1, RESP_OKAY);
					tick();
					chk(32'(pos), (k == 0) ? 32'h1 << i : 32'h0);
					chk(32'(neg), (k == 1) ? 32'h1 << i : 32'h0);
					chk(32'(sine), (k == 2) ? 32'h1 << i : 32'h0);
					rc(pa, 32'h1 << b, RESP_OKAY);
				end
			end
			wr(pa, 32'h00, 4'h1, RESP_OKAY);
		end
		wr(OFS_SW_BASE, 32'h01, 4'h1, RESP_OKAY);
		rc(OFS_SW_BASE, 32'h00, RESP_OKAY);
		wr(8'h24, 32'hc0, 4'h1, RESP_OKAY);
		rc(8'h24, 32'h00, RESP_OKAY);
		for (i = 0; i < 8; i++)
		begin
			k = i % 3;
			wr(OFS_PGA_GAIN, 32'((i % 2) * 128 + k * 40 + i), 4'h1, RESP_OKAY);
			tick();
			chk(32'(pga.bypass), 32'(i % 2));
			chk(32'(pga.ref_shift), 32'(k));
			chk(32'(pga.in_gain), 32'h1 << k);
			chk(32'(pga.amp_gain), 32'h1 << i);
		end
		rc(OFS_PGA_GAIN, 32'haf, RESP_OKAY);
		wr(OFS_PGA_CH, 32'h5a, 4'h1, RESP_OKAY);
		tick();
		chk(32'(chan), 32'h5a);
		wr(OFS_RES_LO, 32'hff, 4'h1, RESP_OKAY);
		rc(OFS_RES_LO, 32'h00, RESP_OKAY);
		// Raw setup bytes keep only their implemented bits.
		wr(OFS_PGA_IN, 32'hff, 4'h1, RESP_OKAY);
		wr(OFS_CLKSEL, 32'hff, 4'h1, RESP_OKAY);
		wr(OFS_SWAP, 32'hff, 4'h1, RESP_OKAY);
		wr(OFS_RATE, 32'hff, 4'h1, RESP_OKAY);
		wr(OFS_CONV, 32'hff, 4'h1, RESP_OKAY);
		rc(OFS_PGA_IN, 32'hfe, RESP_OKAY);
		rc(OFS_CLKSEL, 32'h1f, RESP_OKAY);
		rc(OFS_SWAP, 32'hff, RESP_OKAY);
		rc(OFS_RATE, 32'h7f, RESP_OKAY);
		rc(OFS_CONV, 32'hbf, RESP_OKAY);
		chk(32'({pin_c, clk_c, swp_c, rate_c}), 32'hfe1fff7f);
		chk(32'(ctl_c), 32'hbf);
		// Full-scale stream, shortest window, then latch the second result.
		mb <= 1'b1;
		wr(OFS_RATE, 32'h08, 4'h1, RESP_OKAY);
		wr(OFS_CONV, 32'h00, 4'h1, RESP_OKAY);
		for (k = 0; k < 2; k++)
		begin
			i = 0;
			d = 32'h0;
			while (d[4] !== 1'b1)
			begin
				rd(OFS_CONV, d, r);
				i++;
				if (i > 100)
					fail_out();
			end
			wr(OFS_CONV, (k == 0) ? 32'h00 : 32'h20, 4'h1, RESP_OKAY);
		end
		rc(OFS_RES_LO, 32'h00, RESP_OKAY);
		rc(OFS_RES_MID, 32'h00, RESP_OKAY);
		rc(OFS_RES_HI, 32'h80, RESP_OKAY);
		close_out();
	end
endmodule
